// ### shared/rcb_regs.svh
// register offsets, write masks, field positions and reset value of the response curve register bank
`ifndef RCB_REGS_SVH
`define RCB_REGS_SVH

`define RCB_ADDR_KNEE2_SLOPE_LOW 8'h21
`define RCB_ADDR_KNEE1_LEVEL_B 8'h22
`define RCB_ADDR_KNEE2_LEVEL 8'h25
`define RCB_ADDR_BLACK_COEFF 8'h26
`define RCB_ADDR_THRESH0_HIGH 8'h27
`define RCB_ADDR_THRESH0_LOW 8'h28
`define RCB_ADDR_THRESH1_HIGH 8'h29

`define RCB_RESET_VALUE 8'h00

`define RCB_MASK_FULL 8'hff
`define RCB_MASK_BLACK_COEFF 8'h3f
`define RCB_MASK_THRESH0_LOW 8'hf0

`define RCB_CLIP_MSB 5
`define RCB_CLIP_LSB 3
`define RCB_ALPHA_MSB 2
`define RCB_ALPHA_LSB 0
`define RCB_TH_LOW_MSB 7
`define RCB_TH_LOW_LSB 4

`define RCB_PIXEL_ALL_ONES 12'hfff

`endif

// ### shared/rcb_pkg.sv
// types shared by the response curve register bank
package rcb_pkg;

  typedef enum logic [2:0] {
    RCB_IDX_KNEE2_SLOPE_LOW = 3'b000,
    RCB_IDX_KNEE1_LEVEL_B = 3'b001,
    RCB_IDX_KNEE2_LEVEL = 3'b010,
    RCB_IDX_BLACK_COEFF = 3'b011,
    RCB_IDX_THRESH0_HIGH = 3'b100,
    RCB_IDX_THRESH0_LOW = 3'b101,
    RCB_IDX_THRESH1_HIGH = 3'b110,
    RCB_IDX_NONE = 3'b111
  } rcb_idx_t;

  typedef logic [7:0] rcb_byte_t;
  typedef logic [11:0] rcb_pixel_t;

endpackage : rcb_pkg

// ### src/rcb_byte_reg.sv
// one byte-wide read/write register with a fixed mask of writable bits
`timescale 1ns/1ns
`include "rcb_regs.svh"
module rcb_byte_reg
  import rcb_pkg::*;
#(
  parameter rcb_byte_t WR_MASK = `RCB_MASK_FULL
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire rcb_byte_t wrData,
  output rcb_byte_t value_r
);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value_r <= `RCB_RESET_VALUE;
    end
    else if (wrEn)
    begin
      // masked bits never store, so they read back as zero
      value_r <= wrData & WR_MASK;
    end
  end

endmodule : rcb_byte_reg

// ### src/rcb_clip_mask.sv
// turns the clip select into the mask of black pixel bits that are kept
`timescale 1ns/1ns
`include "rcb_regs.svh"
module rcb_clip_mask
  import rcb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] clipSel,
  output rcb_pixel_t keepMask_r
);

  rcb_pixel_t keepMask_nxt;

  always_comb
  begin
    // each step of the select drops one more top bit
    keepMask_nxt = `RCB_PIXEL_ALL_ONES >> clipSel;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      keepMask_r <= `RCB_PIXEL_ALL_ONES;
    end
    else
    begin
      keepMask_r <= keepMask_nxt;
    end
  end

endmodule : rcb_clip_mask

// ### src/rcb_response_regs.sv
// register bank for response curve knees, black level compensation and defect thresholds
`timescale 1ns/1ns
`include "rcb_regs.svh"
module rcb_response_regs
  import rcb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire rcb_byte_t regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output rcb_byte_t regRdData_r,
  output logic regRdAck_r,
  input wire logic [5:0] knee2SlopeHigh,
  input wire rcb_byte_t firstKneeLevelA,
  output logic [13:0] secondSegmentGradient_r,
  output logic knee2Bypass_r,
  output rcb_byte_t firstKneeLevelB_r,
  output logic knee1Mismatch_r,
  output rcb_byte_t secondKneeLevel_r,
  output rcb_pixel_t blackKeepMask_r,
  output logic [2:0] blackAlpha_r,
  output rcb_pixel_t defectThresholdZero_r,
  output logic [11:4] defectThresholdOneHigh_r
);

  localparam int NUM_REGS = 7;

  // fixed writable-bit masks, in index order
  localparam rcb_byte_t WR_MASKS [NUM_REGS] = '{
    `RCB_MASK_FULL,
    `RCB_MASK_FULL,
    `RCB_MASK_FULL,
    `RCB_MASK_BLACK_COEFF,
    `RCB_MASK_FULL,
    `RCB_MASK_THRESH0_LOW,
    `RCB_MASK_FULL
  };

  rcb_byte_t regQ [NUM_REGS];
  logic [NUM_REGS-1:0] wrSel;
  rcb_idx_t wrIdx;
  rcb_idx_t rdIdx;
  rcb_byte_t rdData_nxt;
  rcb_pixel_t keepMask;

  // address decode shared by the write and read paths
  function automatic rcb_idx_t addr_to_idx(input logic [7:0] addr);
    rcb_idx_t idx;
    idx = RCB_IDX_NONE;
    case (addr)
      `RCB_ADDR_KNEE2_SLOPE_LOW: idx = RCB_IDX_KNEE2_SLOPE_LOW;
      `RCB_ADDR_KNEE1_LEVEL_B: idx = RCB_IDX_KNEE1_LEVEL_B;
      `RCB_ADDR_KNEE2_LEVEL: idx = RCB_IDX_KNEE2_LEVEL;
      `RCB_ADDR_BLACK_COEFF: idx = RCB_IDX_BLACK_COEFF;
      `RCB_ADDR_THRESH0_HIGH: idx = RCB_IDX_THRESH0_HIGH;
      `RCB_ADDR_THRESH0_LOW: idx = RCB_IDX_THRESH0_LOW;
      `RCB_ADDR_THRESH1_HIGH: idx = RCB_IDX_THRESH1_HIGH;
      default: idx = RCB_IDX_NONE;
    endcase
    return idx;
  endfunction : addr_to_idx

  assign wrIdx = addr_to_idx(regAddr);
  assign rdIdx = addr_to_idx(regAddr);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi = gi + 1)
    begin : g_reg
      assign wrSel[gi] = regWrEn && (wrIdx == rcb_idx_t'(gi));
      // reserved bits are cleared by the mask on every write
      rcb_byte_reg #(
        .WR_MASK(WR_MASKS[gi])
      ) u_reg (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wrEn(wrSel[gi]),
        .wrData(regWrData),
        .value_r(regQ[gi])
      );
    end
  endgenerate

  // read path: unmapped addresses answer zero
  always_comb
  begin
    if (rdIdx == RCB_IDX_NONE)
    begin
      rdData_nxt = `RCB_RESET_VALUE;
    end
    else
    begin
      rdData_nxt = regQ[rdIdx];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData_r <= `RCB_RESET_VALUE;
      regRdAck_r <= 1'b0;
    end
    else
    begin
      regRdAck_r <= regRdEn;
      if (regRdEn)
      begin
        regRdData_r <= rdData_nxt;
      end
    end
  end

  // response curve settings
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      secondSegmentGradient_r <= 14'h0000;
      knee2Bypass_r <= 1'b1;
      firstKneeLevelB_r <= `RCB_RESET_VALUE;
      knee1Mismatch_r <= 1'b0;
      secondKneeLevel_r <= `RCB_RESET_VALUE;
    end
    else
    begin
      secondSegmentGradient_r <= {knee2SlopeHigh, regQ[RCB_IDX_KNEE2_SLOPE_LOW]};
      knee2Bypass_r <= (knee2SlopeHigh == 6'h00) && (regQ[RCB_IDX_KNEE2_SLOPE_LOW] == 8'h00);
      firstKneeLevelB_r <= regQ[RCB_IDX_KNEE1_LEVEL_B];
      // the curve is only trustworthy while both copies agree
      knee1Mismatch_r <= firstKneeLevelA != regQ[RCB_IDX_KNEE1_LEVEL_B];
      secondKneeLevel_r <= regQ[RCB_IDX_KNEE2_LEVEL];
    end
  end

  rcb_clip_mask u_clip (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clipSel(regQ[RCB_IDX_BLACK_COEFF][`RCB_CLIP_MSB:`RCB_CLIP_LSB]),
    .keepMask_r(keepMask)
  );

  // black level compensation settings
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blackKeepMask_r <= `RCB_PIXEL_ALL_ONES;
      blackAlpha_r <= 3'h0;
    end
    else
    begin
      blackKeepMask_r <= keepMask;
      blackAlpha_r <= regQ[RCB_IDX_BLACK_COEFF][`RCB_ALPHA_MSB:`RCB_ALPHA_LSB];
    end
  end

  // defect thresholds
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      defectThresholdZero_r <= 12'h000;
      defectThresholdOneHigh_r <= 8'h00;
    end
    else
    begin
      defectThresholdZero_r <= {regQ[RCB_IDX_THRESH0_HIGH],
        regQ[RCB_IDX_THRESH0_LOW][`RCB_TH_LOW_MSB:`RCB_TH_LOW_LSB]};
      defectThresholdOneHigh_r <= regQ[RCB_IDX_THRESH1_HIGH];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_gradient_low;
    regWrEn && regAddr == `RCB_ADDR_KNEE2_SLOPE_LOW
      |=> ##1 secondSegmentGradient_r[7:0] == $past(regWrData, 2);
  endproperty
  a_gradient_low: assert property (p_gradient_low)
    else $error("gradient low byte did not follow write");

  property p_bypass;
    secondSegmentGradient_r == 14'h0000 |-> knee2Bypass_r;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("zero gradient without knee bypass");

  property p_no_bypass;
    secondSegmentGradient_r != 14'h0000 |-> !knee2Bypass_r;
  endproperty
  a_no_bypass: assert property (p_no_bypass)
    else $error("knee bypassed with nonzero gradient");

  property p_knee1_level;
    regWrEn && regAddr == `RCB_ADDR_KNEE1_LEVEL_B |=> ##1 firstKneeLevelB_r == $past(regWrData, 2);
  endproperty
  a_knee1_level: assert property (p_knee1_level)
    else $error("first knee level did not follow write");

  property p_mismatch;
    1'b1 |=> knee1Mismatch_r == ($past(firstKneeLevelA) != firstKneeLevelB_r);
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("mismatch flag disagrees with the two copies");

  property p_knee2_level;
    regWrEn && regAddr == `RCB_ADDR_KNEE2_LEVEL |=> ##1 secondKneeLevel_r == $past(regWrData, 2);
  endproperty
  a_knee2_level: assert property (p_knee2_level)
    else $error("second knee level did not follow write");

  property p_clip;
    regWrEn && regAddr == `RCB_ADDR_BLACK_COEFF
      |=> ##2 blackKeepMask_r == (`RCB_PIXEL_ALL_ONES >> $past(regWrData[5:3], 3));
  endproperty
  a_clip: assert property (p_clip)
    else $error("black keep mask wrong for clip select");

  property p_alpha;
    regWrEn && regAddr == `RCB_ADDR_BLACK_COEFF |=> ##1 blackAlpha_r == $past(regWrData[2:0], 2);
  endproperty
  a_alpha: assert property (p_alpha)
    else $error("averaging coefficient did not follow write");

  property p_thresh0;
    regWrEn && regAddr == `RCB_ADDR_THRESH0_LOW |=> ##1 defectThresholdZero_r[3:0] == $past(regWrData[7:4], 2);
  endproperty
  a_thresh0: assert property (p_thresh0)
    else $error("threshold zero low bits wrong");

  property p_thresh1;
    regWrEn && regAddr == `RCB_ADDR_THRESH1_HIGH |=> ##1 defectThresholdOneHigh_r == $past(regWrData, 2);
  endproperty
  a_thresh1: assert property (p_thresh1)
    else $error("threshold one high bits wrong");

  property p_reserved;
    regRdEn && (regAddr == `RCB_ADDR_BLACK_COEFF || regAddr == `RCB_ADDR_THRESH0_LOW)
      |=> regRdAck_r && (regRdData_r & ~(`RCB_MASK_BLACK_COEFF & `RCB_MASK_THRESH0_LOW) &
        ~($past(regAddr) == `RCB_ADDR_BLACK_COEFF ? `RCB_MASK_BLACK_COEFF : `RCB_MASK_THRESH0_LOW)) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  property p_rd_ack;
    1'b1 |=> regRdAck_r == $past(regRdEn);
  endproperty
  a_rd_ack: assert property (p_rd_ack)
    else $error("read acknowledge not one cycle after read strobe");

  property p_rd_unmapped;
    regRdEn && !(regAddr inside {`RCB_ADDR_KNEE2_SLOPE_LOW, `RCB_ADDR_KNEE1_LEVEL_B, `RCB_ADDR_KNEE2_LEVEL,
      `RCB_ADDR_BLACK_COEFF, `RCB_ADDR_THRESH0_HIGH, `RCB_ADDR_THRESH0_LOW, `RCB_ADDR_THRESH1_HIGH})
      |=> regRdData_r == `RCB_RESET_VALUE;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped address read nonzero");

  property p_rd_gradient_low;
    regRdEn && regAddr == `RCB_ADDR_KNEE2_SLOPE_LOW |=> regRdData_r == secondSegmentGradient_r[7:0];
  endproperty
  a_rd_gradient_low: assert property (p_rd_gradient_low)
    else $error("gradient low byte read disagrees with output");

  property p_rd_knee1;
    regRdEn && regAddr == `RCB_ADDR_KNEE1_LEVEL_B |=> regRdData_r == firstKneeLevelB_r;
  endproperty
  a_rd_knee1: assert property (p_rd_knee1)
    else $error("first knee level read disagrees with output");

  property p_rd_knee2;
    regRdEn && regAddr == `RCB_ADDR_KNEE2_LEVEL |=> regRdData_r == secondKneeLevel_r;
  endproperty
  a_rd_knee2: assert property (p_rd_knee2)
    else $error("second knee level read disagrees with output");

  property p_rd_thresh0;
    regRdEn && regAddr == `RCB_ADDR_THRESH0_HIGH |=> regRdData_r == defectThresholdZero_r[11:4];
  endproperty
  a_rd_thresh0: assert property (p_rd_thresh0)
    else $error("threshold zero high read disagrees with output");

  property p_rd_thresh1;
    regRdEn && regAddr == `RCB_ADDR_THRESH1_HIGH |=> regRdData_r == defectThresholdOneHigh_r;
  endproperty
  a_rd_thresh1: assert property (p_rd_thresh1)
    else $error("threshold one high read disagrees with output");

endmodule : rcb_response_regs

// ### testbench/rcb_host_model.sv
// host side model: issues byte register accesses and drives the neighbouring register values
`timescale 1ns/1ns
module rcb_host_model
  import rcb_pkg::*;
(
  input wire logic sys_clk,
  input wire rcb_byte_t regRdData_r,
  input wire logic regRdAck_r,
  output logic [7:0] regAddr,
  output rcb_byte_t regWrData,
  output logic regWrEn,
  output logic regRdEn,
  output logic [5:0] knee2SlopeHigh,
  output rcb_byte_t firstKneeLevelA
);
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    knee2SlopeHigh = 6'h00;
    firstKneeLevelA = 8'h00;
  end

  // released address and data show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input rcb_byte_t d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output rcb_byte_t d, output logic ok);
    int n;
    @(negedge sys_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    n = 0;
    while (regRdAck_r !== 1'b1 && n < 3)
    begin
      @(negedge sys_clk);
      n++;
    end
    ok = regRdAck_r;
    d = regRdData_r;
  endtask : rd

  task automatic setNb(input logic [5:0] hi, input rcb_byte_t a);
    @(negedge sys_clk);
    knee2SlopeHigh = hi;
    firstKneeLevelA = a;
  endtask : setNb
endmodule : rcb_host_model

// ### testbench/rcb_response_regs_bench.sv
// self-checking bench for the response curve register bank
`timescale 1ns/1ns
module rcb_response_regs_bench
  import rcb_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr;
  rcb_byte_t regWrData, regRdData_r, firstKneeLevelA, firstKneeLevelB_r, secondKneeLevel_r;
  rcb_byte_t shadow [256];
  logic regWrEn, regRdEn, regRdAck_r, knee2Bypass_r, knee1Mismatch_r;
  logic [5:0] knee2SlopeHigh;
  logic [5:0] slopeHi = 6'h00;
  rcb_byte_t copyA = 8'h00;
  logic [13:0] secondSegmentGradient_r;
  rcb_pixel_t blackKeepMask_r, defectThresholdZero_r;
  logic [2:0] blackAlpha_r;
  logic [11:4] defectThresholdOneHigh_r;
  int err_total = 0;
  int cmp_count = 0;

  always #10 sys_clk = ~sys_clk;

  rcb_response_regs i_rcb_response_regs (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
    .regRdAck_r(regRdAck_r), .knee2SlopeHigh(knee2SlopeHigh), .firstKneeLevelA(firstKneeLevelA),
    .secondSegmentGradient_r(secondSegmentGradient_r), .knee2Bypass_r(knee2Bypass_r),
    .firstKneeLevelB_r(firstKneeLevelB_r), .knee1Mismatch_r(knee1Mismatch_r),
    .secondKneeLevel_r(secondKneeLevel_r), .blackKeepMask_r(blackKeepMask_r), .blackAlpha_r(blackAlpha_r),
    .defectThresholdZero_r(defectThresholdZero_r), .defectThresholdOneHigh_r(defectThresholdOneHigh_r));

  rcb_host_model i_rcb_host_model (.sys_clk(sys_clk), .regRdData_r(regRdData_r), .regRdAck_r(regRdAck_r),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .knee2SlopeHigh(knee2SlopeHigh), .firstKneeLevelA(firstKneeLevelA));

  function automatic logic isMapped(input logic [7:0] a);
    return a inside {8'h21, 8'h22, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29};
  endfunction : isMapped

  function automatic rcb_byte_t wmask(input logic [7:0] a);
    return (a == 8'h26) ? 8'h3f : (a == 8'h28) ? 8'hf0 : 8'hff;
  endfunction : wmask

  task automatic summarize;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic checkOutputs;
    check("gradient", secondSegmentGradient_r, {slopeHi, shadow[8'h21]});
    check("bypass", knee2Bypass_r, {slopeHi, shadow[8'h21]} == 14'h0000);
    check("knee1B", firstKneeLevelB_r, shadow[8'h22]);
    check("mismatch", knee1Mismatch_r, copyA != shadow[8'h22]);
    check("knee2", secondKneeLevel_r, shadow[8'h25]);
    check("keepMask", blackKeepMask_r, 12'hfff >> shadow[8'h26][5:3]);
    check("alpha", blackAlpha_r, shadow[8'h26][2:0]);
    check("thr0", defectThresholdZero_r, {shadow[8'h27], shadow[8'h28][7:4]});
    check("defect_threshold_one", defectThresholdOneHigh_r, shadow[8'h29]);
  endtask : checkOutputs

  task automatic doWr(input logic [7:0] a, input rcb_byte_t d);
    i_rcb_host_model.wr(a, d);
    if (isMapped(a))
      shadow[a] = d & wmask(a);
    repeat (3) @(negedge sys_clk);
    checkOutputs();
  endtask : doWr

  task automatic doRd(input logic [7:0] a);
    rcb_byte_t d;
    logic ok;
    i_rcb_host_model.rd(a, d, ok);
    check("ack", ok, 1'b1);
    check("rdData", d, shadow[a]);
    @(negedge sys_clk);
    check("ackDrop", regRdAck_r, 1'b0);
    check("rdHold", regRdData_r, shadow[a]);
  endtask : doRd

  task automatic doNb(input logic [5:0] hi, input rcb_byte_t a);
    i_rcb_host_model.setNb(hi, a);
    slopeHi = hi;
    copyA = a;
    repeat (3) @(negedge sys_clk);
    checkOutputs();
  endtask : doNb

  initial
  begin
    void'($urandom(32'h274d_6de1));
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    checkOutputs();
    for (int a = 8'h20; a <= 8'h2a; a++) doRd(8'(a));
    doWr(8'h21, 8'h01);
    doNb(6'h00, 8'h00);
    doWr(8'h21, 8'h00);
    doNb(6'h20, 8'h00);
    doNb(6'h00, 8'h5a);
    doWr(8'h22, 8'h5a);
    for (int c = 0; c < 8; c++) doWr(8'h26, {2'b11, 3'(c), ~3'(c)});
    doWr(8'h28, 8'hff);
    doRd(8'h28);
    doWr(8'h23, 8'hff);
    doRd(8'h23);
    repeat (40)
    begin
      logic [7:0] a;
      a = 8'h20 + 8'($urandom_range(10));
      if ($urandom_range(4) == 0)
        doNb(6'($urandom), 8'($urandom));
      doWr(a, 8'($urandom));
      doRd(a);
    end
    // reset in mid-run: every byte register returns to zero while knee2Bypass_r sets and the keep mask goes to all ones
    @(negedge sys_clk);
    rst_n = 1'b0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    @(negedge sys_clk);
    check("rstBypass", knee2Bypass_r, 1'b1);
    rst_n = 1'b1;
    @(negedge sys_clk);
    checkOutputs();
    for (int a = 8'h21; a <= 8'h29; a++) doRd(8'(a));
    summarize();
  end

  initial
  begin
    #100_000;
    err_total++;
    summarize();
  end
endmodule : rcb_response_regs_bench
